// >>> src/clk_hub_pkg.sv
// package: constants, register map and carrier types of the regional clock hub
// assumes: one system clock, apb register access, 32-bit data
package clk_hub_pkg;

  // network sizes
  localparam int TOP_CLKS   = 32;
  localparam int BOT_CLKS   = 32;
  localparam int CTR_DATA   = 16;
  localparam int CTR_INS    = 80;
  localparam int GLB_CLKS   = 48;
  localparam int XBAR_CNT   = 2;
  localparam int XBAR_OUTS  = 8;
  localparam int REG_OUTS   = 16;
  localparam int XBAR_DATA  = 2;
  localparam int XBAR_INS   = 50;
  localparam int CTRL_LINES = 16;
  localparam int FAB_LINES  = 32;
  localparam int SEL_W      = 6;
  localparam int CSEL_W     = 7;
  localparam int ADDR_W     = 12;

  // register offsets (byte addresses)
  localparam logic [11:0] OUT_CFG_BASE = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h040;
  localparam logic [11:0] CTR_SEL_BASE = 12'h100;

  // output configuration field positions
  localparam int SELA_LSB  = 0;
  localparam int SELB_LSB  = 8;
  localparam int RATIO_LSB = 16;
  localparam int DIVEN_BIT = 18;
  localparam int MODE_LSB  = 20;
  localparam int CTRL_LSB  = 24;

  // reset values
  localparam logic [31:0] OUT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  // divider: half period in input cycles is ratio code plus this
  localparam logic [2:0] DIV_HALF_BASE = 3'h1;

  typedef enum logic [1:0] {
    MODE_PASS,
    MODE_GATE,
    MODE_SWITCH
  } stage_mode_type;

  typedef struct packed {
    logic [3:0]     ctrlIdx;
    stage_mode_type mode;
    logic           divEn;
    logic [1:0]     ratio;
    logic [5:0]     selB;
    logic [5:0]     selA;
  } out_cfg_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

// >>> src/clk_out_stage.sv
// one regional output: divider, bypass mux, dynamic gate, glitchless switch
// assumes: clock inputs are levels sampled on clk_sys
`timescale 1ns/1ns
`default_nettype none
module clk_out_stage
  import clk_hub_pkg::*;
(
  // system
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // sources and control
  input  wire logic                        clkA,
  input  wire logic                        clkB,
  input  wire logic                        ctrl,
  // static configuration
  input  wire logic                        divEn,
  input  wire logic [1:0]                  ratio,
  input  wire clk_hub_pkg::stage_mode_type mode,
  // results
  output logic                             clkOut,
  output logic                             onB
);

  logic       clkA_q;
  logic [2:0] divCnt_r;
  logic       divClk_r;
  logic       gateEn_r;
  logic       enA_r;
  logic       enB_r;
  logic       primary;
  logic       wantB;
  logic       rise;
  logic [2:0] half;
  logic       clkOut_nxt;

  assign rise    = clkA & ~clkA_q;
  assign half    = {1'b0, ratio} + DIV_HALF_BASE;
  assign primary = divEn ? divClk_r : clkA;
  assign wantB   = (mode == MODE_SWITCH) & ctrl;
  assign onB     = enB_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clkA_q <= 1'b0;
    end else begin
      clkA_q <= clkA;
    end
  end

  // divider toggles after half the ratio of input rising edges
  always_ff @(posedge clk_sys) begin
    if (rst || !divEn) begin
      divCnt_r <= 3'h0;
      divClk_r <= 1'b0;
    end else if (rise) begin
      if (divCnt_r == half - 3'h1) begin
        divCnt_r <= 3'h0;
        divClk_r <= ~divClk_r;
      end else begin
        divCnt_r <= divCnt_r + 3'h1;
      end
    end
  end

  // enable taken only while the clock is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gateEn_r <= 1'b0;
    end else if (mode == MODE_GATE && !primary) begin
      gateEn_r <= ctrl;
    end
  end

  // deselect old source on its low phase, then select new on its low phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enA_r <= 1'b1;
    end else if (wantB && !primary) begin
      enA_r <= 1'b0;
    end else if (!wantB && !enB_r && !primary) begin
      enA_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enB_r <= 1'b0;
    end else if (!wantB && !clkB) begin
      enB_r <= 1'b0;
    end else if (wantB && !enA_r && !clkB) begin
      enB_r <= 1'b1;
    end
  end

  always_comb begin
    case (mode)
      MODE_PASS:   clkOut_nxt = primary;
      MODE_GATE:   clkOut_nxt = primary & gateEn_r;
      MODE_SWITCH: clkOut_nxt = (primary & enA_r) | (clkB & enB_r);
      default:     clkOut_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clkOut <= 1'b0;
    end else begin
      clkOut <= clkOut_nxt;
    end
  end

  sequence divRise_s;
    divEn && rise && (divCnt_r == half - 3'h1);
  endsequence

  gate_low_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) && $changed(gateEn_r) |-> !$past(primary))
    else $error("gate enable changed while clock high");

  switch_exclusive_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(enA_r && enB_r))
    else $error("both switch sources enabled");

  switch_drop_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) && ($fell(enA_r) || $rose(enA_r)) |-> !$past(primary))
    else $error("source A enable moved while A high");

  div_toggle_a: assert property (@(posedge clk_sys) disable iff (rst)
    divRise_s ##1 divEn |-> divClk_r != $past(divClk_r))
    else $error("divider missed its toggle");

  gate_closed_a: assert property (@(posedge clk_sys) disable iff (rst)
    mode == MODE_GATE && !gateEn_r |=> !clkOut)
    else $error("closed gate passed a clock");

endmodule
`default_nettype wire

// >>> src/regional_clock_hub.sv
// regional clock hub with its feeding central hub and apb configuration
// assumes: clock and data inputs sampled on clk_sys, apb master on clk_sys
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module regional_clock_hub
  import clk_hub_pkg::*;
#(
  parameter int OUTS = REG_OUTS
)
(
  // system
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // apb register access
  input  wire clk_hub_pkg::apb_req_type  apbReq,
  output clk_hub_pkg::apb_rsp_type       apbRsp,
  // central hub sources
  input  wire logic [TOP_CLKS-1:0]       topClk,
  input  wire logic [BOT_CLKS-1:0]       botClk,
  input  wire logic [CTR_DATA-1:0]       ctrData,
  // fabric data lines into the regional hub
  input  wire logic [FAB_LINES-1:0]      fabData,
  // results
  output logic [GLB_CLKS-1:0]            glbClk,
  output logic [OUTS-1:0]                regionClk
);

  logic [CTR_INS-1:0]  ctrIn;
  logic [CSEL_W-1:0]   ctrSel_r [GLB_CLKS];
  logic [GLB_CLKS-1:0] glbClk_nxt;
  out_cfg_type         cfg_r    [OUTS];
  logic [OUTS-1:0]     srcA;
  logic [OUTS-1:0]     srcB;
  logic [OUTS-1:0]     ctrlLine;
  logic [OUTS-1:0]     onB;
  logic [OUTS-1:0]     stageOut;
  logic                access;
  logic                wrEn;
  logic                cfgHit;
  logic                ctrHit;
  logic                statHit;
  logic                mapped;
  logic [5:0]          wordIdx;
  logic [31:0]         rdata_nxt;
  logic [31:0]         prdata_r;

  // central hub input order: top, bottom, data
  assign ctrIn = {ctrData, botClk, topClk};

  always_comb begin
    glbClk_nxt = '0;
    for (int j = 0; j < GLB_CLKS; j++) begin
      if (int'(ctrSel_r[j]) < CTR_INS) begin
        glbClk_nxt[j] = ctrIn[ctrSel_r[j]];
      end
    end
  end

  // one registered global bus drives the whole trunk
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      glbClk <= '0;
    end else begin
      glbClk <= glbClk_nxt;
    end
  end

  // apb decode
  assign access  = apbReq.psel & apbReq.penable;
  assign wrEn    = access & apbReq.pwrite;
  assign wordIdx = apbReq.paddr[7:2];
  assign cfgHit  = (apbReq.paddr[11:8] == OUT_CFG_BASE[11:8])
                 && (apbReq.paddr < STATUS_OFS) && (apbReq.paddr[1:0] == 2'b00);
  assign statHit = (apbReq.paddr == STATUS_OFS);
  assign ctrHit  = (apbReq.paddr[11:8] == CTR_SEL_BASE[11:8])
                 && (int'(wordIdx) < GLB_CLKS) && (apbReq.paddr[1:0] == 2'b00);
  assign mapped  = cfgHit | statHit | ctrHit;

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = access & ~mapped;
  assign apbRsp.prdata  = prdata_r;

  // central selects, reset to straight-through order
  generate
    for (genvar j = 0; j < GLB_CLKS; j++) begin : g_ctrSel
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ctrSel_r[j] <= CSEL_W'(j);
        end else if (wrEn && ctrHit && int'(wordIdx) == j) begin
          ctrSel_r[j] <= apbReq.pwdata[CSEL_W-1:0];
        end
      end
    end
  endgenerate

  // per-output configuration and stage
  generate
    for (genvar i = 0; i < OUTS; i++) begin : g_out
      localparam int XB   = i / XBAR_OUTS;
      localparam int DLSB = XB * CTRL_LINES;

      logic [XBAR_INS-1:0]   xbarIn;
      logic [CTRL_LINES-1:0] ctrlSet;

      // only two data lines per crossbar join the clock choices
      assign xbarIn  = {fabData[DLSB +: XBAR_DATA], glbClk};
      assign ctrlSet = fabData[DLSB +: CTRL_LINES];

      assign srcA[i]     = (int'(cfg_r[i].selA) < XBAR_INS) ? xbarIn[cfg_r[i].selA] : 1'b0;
      assign srcB[i]     = (int'(cfg_r[i].selB) < XBAR_INS) ? xbarIn[cfg_r[i].selB] : 1'b0;
      assign ctrlLine[i] = ctrlSet[cfg_r[i].ctrlIdx];

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cfg_r[i] <= out_cfg_type'(OUT_CFG_RST);
        end else if (wrEn && cfgHit && int'(wordIdx) == i) begin
          cfg_r[i].selA    <= apbReq.pwdata[SELA_LSB +: SEL_W];
          cfg_r[i].selB    <= apbReq.pwdata[SELB_LSB +: SEL_W];
          cfg_r[i].divEn   <= apbReq.pwdata[DIVEN_BIT];
          cfg_r[i].mode    <= stage_mode_type'(apbReq.pwdata[MODE_LSB +: 2]);
          cfg_r[i].ctrlIdx <= apbReq.pwdata[CTRL_LSB +: 4];
          if (!cfg_r[i].divEn) begin
            cfg_r[i].ratio <= apbReq.pwdata[RATIO_LSB +: 2];
          end
        end
      end

      clk_out_stage u_stage (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkA    (srcA[i]),
        .clkB    (srcB[i]),
        .ctrl    (ctrlLine[i]),
        .divEn   (cfg_r[i].divEn),
        .ratio   (cfg_r[i].ratio),
        .mode    (cfg_r[i].mode),
        .clkOut  (stageOut[i]),
        .onB     (onB[i])
      );

      ratio_static_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) && $changed(cfg_r[i].ratio) |-> !$past(cfg_r[i].divEn))
        else $error("divide ratio changed while dividing");
    end
  endgenerate

  // both crossbar buses form the regional bus
  assign regionClk = stageOut;

  // read data
  always_comb begin
    rdata_nxt = RDATA_ZERO;
    if (cfgHit) begin
      rdata_nxt[SELA_LSB +: SEL_W]  = cfg_r[wordIdx[3:0]].selA;
      rdata_nxt[SELB_LSB +: SEL_W]  = cfg_r[wordIdx[3:0]].selB;
      rdata_nxt[RATIO_LSB +: 2]     = cfg_r[wordIdx[3:0]].ratio;
      rdata_nxt[DIVEN_BIT]          = cfg_r[wordIdx[3:0]].divEn;
      rdata_nxt[MODE_LSB +: 2]      = cfg_r[wordIdx[3:0]].mode;
      rdata_nxt[CTRL_LSB +: 4]      = cfg_r[wordIdx[3:0]].ctrlIdx;
    end else if (statHit) begin
      rdata_nxt[15:0]  = 16'(onB);
      rdata_nxt[31:16] = 16'(regionClk);
    end else if (ctrHit) begin
      rdata_nxt[CSEL_W-1:0] = ctrSel_r[wordIdx];
    end
  end

  // read data stands from the setup edge through the access edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_r <= RDATA_ZERO;
    end else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  sequence apbAccess_s;
    apbReq.psel && apbReq.penable;
  endsequence

  apb_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
    apbAccess_s |-> apbRsp.pready)
    else $error("apb access not answered at once");

  apb_unmapped_a: assert property (@(posedge clk_sys) disable iff (rst)
    apbAccess_s and !mapped |-> apbRsp.pslverr)
    else $error("unmapped access without error");

  central_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    int'(ctrSel_r[0]) < CTR_INS |=> glbClk[0] == $past(ctrIn[ctrSel_r[0]]))
    else $error("global clock 0 not from its selected input");

  central_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrEn && ctrHit && wordIdx == 6'h00 |=> ctrSel_r[0] == $past(apbReq.pwdata[CSEL_W-1:0]))
    else $error("central select write lost");

  region_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_r[0].mode == MODE_PASS && !cfg_r[0].divEn ##1 cfg_r[0].mode == MODE_PASS
    |-> regionClk[0] == $past(srcA[0]))
    else $error("undivided pass output wrong");

  data_lines_a: assert property (@(posedge clk_sys) disable iff (rst)
    int'(cfg_r[OUTS-1].selA) == GLB_CLKS + 1 |-> srcA[OUTS-1] == fabData[CTRL_LINES + 1])
    else $error("data line routing wrong");

  central_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
    int'(ctrSel_r[1]) >= CTR_INS |=> !glbClk[1])
    else $error("refused central select not held low");

  xbar_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
    int'(cfg_r[3].selA) >= XBAR_INS |-> !srcA[3])
    else $error("refused crossbar select not held low");

  apb_mapped_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
    apbAccess_s and mapped |-> !apbRsp.pslverr)
    else $error("mapped access flagged as error");

endmodule
`default_nettype wire

// >>> verification/fabric_model.sv
// fabric side model: free-running source clocks and bench-set data lines
// assumes: clk_sys and rst of the hub, all lines sampled on clk_sys
`timescale 1ns/1ns
`default_nettype none
module fabric_model
  import clk_hub_pkg::*;
(
  // system
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // levels set by the bench
  input  wire logic [FAB_LINES-1:0] lvl,
  // toward the hub
  output logic [TOP_CLKS-1:0]       topClk,
  output logic [BOT_CLKS-1:0]       botClk,
  output logic [CTR_DATA-1:0]       ctrData,
  output logic [FAB_LINES-1:0]      fabData
);
  logic [2:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // even top lines halve clk_sys, bottom lines divide it by 8
  assign topClk  = {16{cnt_r[1:0]}};
  assign botClk  = {32{cnt_r[2]}};
  assign ctrData = lvl[CTR_DATA-1:0];
  // control lines, one gated and one switched output at a time
  assign fabData = lvl;
endmodule
`default_nettype wire

// >>> verification/regional_clock_hub_bench.sv
// bench: apb configuration calls and clock output measurements
// assumes: fabric_model drives all hub sources
`timescale 1ns/1ns
`default_nettype none
module regional_clock_hub_bench;
  import clk_hub_pkg::*;
  logic                 clk_sys;
  logic                 rst;
  apb_req_type          apbReq;
  apb_rsp_type          apbRsp;
  logic [TOP_CLKS-1:0]  topClk;
  logic [BOT_CLKS-1:0]  botClk;
  logic [CTR_DATA-1:0]  ctrData;
  logic [FAB_LINES-1:0] fabData;
  logic [FAB_LINES-1:0] lvl;
  logic [GLB_CLKS-1:0]  glbClk;
  logic [REG_OUTS-1:0]  regionClk;
  logic [31:0]          rd;
  logic                 err;
  int                   fail_count;
  int                   checks_done;

  regional_clock_hub #(.OUTS(REG_OUTS)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .topClk(topClk), .botClk(botClk), .ctrData(ctrData), .fabData(fabData),
    .glbClk(glbClk), .regionClk(regionClk));
  fabric_model u_fab (
    .clk_sys(clk_sys), .rst(rst), .lvl(lvl), .topClk(topClk),
    .botClk(botClk), .ctrData(ctrData), .fabData(fabData));

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h1, 32'h0);
      summarize();
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  function automatic logic [31:0] cfg(input int a, b, r, de, m, c);
    return 32'((a << SELA_LSB) | (b << SELB_LSB) | (r << RATIO_LSB) |
               (de << DIVEN_BIT) | (m << MODE_LSB) | (c << CTRL_LSB));
  endfunction

  // bounded wait for an output level, then compare
  task automatic waitOut(input int i, input logic v);
    int n;
    n = 0;
    while (regionClk[i] !== v && n < 8) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(regionClk[i]), 32'(v));
  endtask

  // skip two changes, then count edges to the next change
  task automatic measure(input int i, input int exp);
    logic last;
    int   n;
    repeat (2) begin
      last = regionClk[i];
      n = 0;
      while (regionClk[i] === last && n < 40) begin
        @(posedge clk_sys);
        n++;
      end
    end
    last = regionClk[i];
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (regionClk[i] === last && n < 40);
    chk(32'(n), 32'(exp));
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    chk(32'h1, 32'h0);
    summarize();
  end

  initial begin
    rst = 1'b1;
    apbReq = '0;
    lvl = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    chk(glbClk[31:0], 32'h0);
    chk(32'(regionClk), 32'h0);
    rst <= 1'b0;
    // reset config, unmapped place
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, OUT_CFG_RST);
    apb(1'b1, 12'h080, 32'hFFFF_FFFF);
    apb(1'b0, 12'h080, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // central hub: global 0 from data line 0, global 1 refused code
    apb(1'b1, CTR_SEL_BASE, 32'h0000_0040);
    apb(1'b1, 12'h104, 32'h0000_0050);
    apb(1'b0, CTR_SEL_BASE, 32'h0);
    chk(rd, 32'h0000_0040);
    for (int v = 1; v >= 0; v--) begin
      lvl <= 32'(v);
      repeat (3) @(posedge clk_sys);
      chk(32'(glbClk[0]), 32'(v));
      chk(32'(glbClk[1]), 32'h0);
    end
    // regional selection of fabric lines
    apb(1'b1, 12'h000, cfg(48, 0, 0, 0, 0, 0));
    apb(1'b1, 12'h03C, cfg(49, 0, 0, 0, 0, 0));
    apb(1'b1, 12'h00C, cfg(50, 0, 0, 0, 0, 0));
    lvl <= 32'h0002_0001;
    waitOut(0, 1'b1);
    waitOut(15, 1'b1);
    waitOut(3, 1'b0);
    lvl <= 32'h0;
    waitOut(0, 1'b0);
    waitOut(15, 1'b0);
    // divider ratios and bypass
    apb(1'b1, 12'h004, cfg(2, 0, 0, 0, 0, 0));
    measure(1, 1);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 12'h004, cfg(2, 0, r, 0, 0, 0));
      apb(1'b1, 12'h004, cfg(2, 0, r, 1, 0, 0));
      measure(1, 2 * (r + 1));
      measure(1, 2 * (r + 1));
    end
    apb(1'b1, 12'h004, cfg(2, 0, 0, 1, 0, 0));
    measure(1, 8);
    // divided clock into the gate, enable on line 5
    apb(1'b1, 12'h008, cfg(2, 0, 0, 1, 1, 5));
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, cfg(2, 0, 0, 1, 1, 5));
    repeat (6) @(posedge clk_sys);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      chk(32'(regionClk[2]), 32'h0);
    end
    lvl <= 32'h0000_0020;
    measure(2, 2);
    // switch on output 10, select on crossbar 1 line 3
    apb(1'b1, 12'h028, cfg(2, 32, 0, 0, 2, 3));
    measure(10, 1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[10]), 32'h0);
    lvl <= 32'h0008_0000;
    repeat (16) @(posedge clk_sys);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[10]), 32'h1);
    measure(10, 4);
    summarize();
  end
endmodule
`default_nettype wire
